/* File: core/rlcex_core.sv */
// scalar in-order real-time core with local instruction memory, data and slave buses
`timescale 1ns/1ps
`default_nettype none
module rlcex_core #(
   parameter int unsigned INSTRUCTION_MEMORY_WORDS = rlcex_pkg::INSTRUCTION_MEMORY_WORDS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [31:0] ext_status,
   input wire logic s_req,
   input wire logic s_we,
   input wire logic [rlcex_pkg::SAW-1:0] s_addr,
   input wire logic [31:0] s_wdata,
   output logic [31:0] s_rdata,
   output logic s_ack,
   output logic m0_req,
   output logic m1_req,
   output logic m_we,
   output logic [31:0] m_addr,
   output logic [31:0] m_wdata,
   input wire logic [31:0] m0_rdata,
   input wire logic m0_ack,
   input wire logic [31:0] m1_rdata,
   input wire logic m1_ack,
   output logic halted
);
   typedef enum logic [1:0] {S_HALT, S_FETCH, S_EXEC, S_MEM} rlcex_state_t;

   rlcex_state_t st_q;
   logic [31:0] rf_q [rlcex_pkg::NREG];
   logic [31:0] stat_s1_q, stat_s2_q;
   logic [rlcex_pkg::INSTRUCTION_MEMORY_AW-1:0] pc_q;
   logic run_q;
   logic ld_q;
   logic [4:0] ldrd_q;
   logic s_pend_q;
   logic [1:0] s_rg_q;
   logic [7:0] s_off_q;
   logic [31:0] instr;
   logic [31:0] ram_rdata;
   logic ram_we;
   logic [rlcex_pkg::INSTRUCTION_MEMORY_AW-1:0] ram_addr;
   logic s_take;
   logic [1:0] s_rg;

   // operand readers: register 31 returns the synchronised status pins
   function automatic logic [31:0] rd_reg(input logic [4:0] i);
      rd_reg = (i == rlcex_pkg::STAT_REG) ? stat_s2_q : rf_q[i];
   endfunction

   function automatic logic [31:0] ctab(input logic [4:0] i);
      unique case (i)
         rlcex_pkg::CT_IDX_INTERRUPT_CONTROLLER_UNIT: ctab = rlcex_pkg::CT_INTERRUPT_CONTROLLER_UNIT;
         rlcex_pkg::CT_IDX_CAPT: ctab = rlcex_pkg::CT_CAPT;
         rlcex_pkg::CT_IDX_CFG: ctab = rlcex_pkg::CT_CFG;
         default: ctab = 32'h0000_0000;
      endcase
   endfunction

   // picks a bit, byte, halfword or word out of a register
   function automatic logic [31:0] opnd(input logic [31:0] v,
         input logic [1:0] g, input logic [4:0] p);
      unique case (g)
         rlcex_pkg::G_BIT: opnd = {31'h0, v[p]};
         rlcex_pkg::G_BYTE: opnd = {24'h0, v[8*p[1:0] +: 8]};
         rlcex_pkg::G_HALF: opnd = {16'h0, v[16*p[0] +: 16]};
         default: opnd = v;
      endcase
   endfunction

   // instruction fields
   logic [3:0] op;
   logic [4:0] f_rd, f_rs1, f_rs2, f_offr;
   logic [1:0] f_gran, f_mode;
   logic [4:0] f_part;
   logic f_cflag;
   logic [31:0] a_val, b_val, alu_res, base, off, ea, upd;
   logic [31:0] imm8;

   assign instr = ram_rdata;
   assign op = instr[rlcex_pkg::F_OP +: 4];
   assign f_rd = instr[rlcex_pkg::F_RD +: 5];
   assign f_rs1 = instr[rlcex_pkg::F_RS1 +: 5];
   assign f_rs2 = instr[rlcex_pkg::F_RS2 +: 5];
   assign f_gran = instr[rlcex_pkg::F_GRAN +: 2];
   assign f_part = instr[rlcex_pkg::F_PART +: 5];
   assign f_cflag = instr[rlcex_pkg::F_CFLAG];
   assign f_mode = instr[rlcex_pkg::F_MODE +: 2];
   assign f_offr = instr[rlcex_pkg::F_OFFR +: 5];
   assign imm8 = {24'h0, instr[7:0]};
   always_comb begin
      a_val = rd_reg(f_rs1);
      b_val = opnd(rd_reg(f_rs2), f_gran, f_part);
   end

   // unsigned arithmetic only, wraps modulo 2^32
   always_comb begin
      unique case (op)
         rlcex_pkg::OP_SUB: alu_res = a_val - b_val;
         rlcex_pkg::OP_AND: alu_res = a_val & b_val;
         rlcex_pkg::OP_OR: alu_res = a_val | b_val;
         default: alu_res = a_val + b_val;
      endcase
   end

   // effective address for loads and stores
   always_comb begin
      base = f_cflag ? ctab(f_rs1) : a_val;
      off = 32'h0000_0000;
      upd = 32'h0000_0000;
      unique case (f_mode)
         rlcex_pkg::M_REGOFF: off = rd_reg(f_offr);
         rlcex_pkg::M_IMMOFF: off = f_cflag ? imm8 : imm8;
         rlcex_pkg::M_POSTINC: begin
            off = f_cflag ? rd_reg(f_offr) : 32'h0000_0000;
            upd = (f_cflag ? rd_reg(f_offr) : a_val) + imm8;
         end
         rlcex_pkg::M_PREDEC: begin
            upd = (f_cflag ? rd_reg(f_offr) : a_val) - imm8;
            off = f_cflag ? upd : 32'h0000_0000;
         end
      endcase
      if (f_mode == rlcex_pkg::M_PREDEC && !f_cflag) begin
         ea = upd;
      end else begin
         ea = base + off;
      end
   end

   // fetch and slave share the one memory port; the slave gets it only while halted
   assign ram_addr = (st_q == S_HALT) ? s_addr[2 +: rlcex_pkg::INSTRUCTION_MEMORY_AW]
                                      : pc_q;
   assign s_rg = s_addr[rlcex_pkg::SAW-1 -: 2];
   assign s_take = s_req && !s_pend_q && !s_ack;
   assign ram_we = s_take && s_we && s_rg == rlcex_pkg::RG_INSTRUCTION_MEMORY
                   && st_q == S_HALT;

   rlcex_ram #(
      .WIDTH(32),
      .DEPTH(INSTRUCTION_MEMORY_WORDS),
      .AW(rlcex_pkg::INSTRUCTION_MEMORY_AW)
   ) u_instruction_memory (
      .clk(clk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(s_wdata),
      .rdata(ram_rdata)
   );

   // two-stage sync of status pins before the core reads them
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stat_s1_q <= 32'h0000_0000;
         stat_s2_q <= 32'h0000_0000;
      end else begin
         stat_s1_q <= ext_status;
         stat_s2_q <= stat_s1_q;
      end
   end

   // sequencer: fetch, execute, optional data wait; never overlaps
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= S_HALT;
         pc_q <= '0;
      end else begin
         unique case (st_q)
            S_HALT: if (run_q) st_q <= S_FETCH;
            S_FETCH: st_q <= run_q ? S_EXEC : S_HALT;
            S_EXEC: begin
               pc_q <= pc_q + 1'b1;
               st_q <= S_FETCH;
               unique case (op)
                  rlcex_pkg::OP_LD, rlcex_pkg::OP_ST: st_q <= S_MEM;
                  rlcex_pkg::OP_JMP: pc_q <= instr[rlcex_pkg::INSTRUCTION_MEMORY_AW-1:0];
                  rlcex_pkg::OP_BNZ: if (a_val != 32'h0000_0000) begin
                     pc_q <= instr[rlcex_pkg::INSTRUCTION_MEMORY_AW-1:0];
                  end
                  rlcex_pkg::OP_HALT: st_q <= S_HALT;
                  default: ;
               endcase
            end
            S_MEM: if (m0_ack || m1_ack) st_q <= S_FETCH;
         endcase
      end
   end

   // data bus request: local space on interface 0, system on interface 1
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         m0_req <= 1'b0;
         m1_req <= 1'b0;
         m_we <= 1'b0;
         m_addr <= 32'h0000_0000;
         m_wdata <= 32'h0000_0000;
         ld_q <= 1'b0;
         ldrd_q <= 5'h00;
      end else if (st_q == S_EXEC && (op == rlcex_pkg::OP_LD
                                    || op == rlcex_pkg::OP_ST)) begin
         m0_req <= ea < rlcex_pkg::SYS_BASE;
         m1_req <= ea >= rlcex_pkg::SYS_BASE;
         m_we <= op == rlcex_pkg::OP_ST;
         m_addr <= ea;
         m_wdata <= rd_reg(f_rd);
         ld_q <= op == rlcex_pkg::OP_LD;
         ldrd_q <= f_rd;
      end else if (m0_ack || m1_ack) begin
         m0_req <= 1'b0;
         m1_req <= 1'b0;
         m_we <= 1'b0;
      end
   end

   // register file: core writes while running, debug writes while halted
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < rlcex_pkg::NREG; i++) begin
            rf_q[i] <= 32'h0000_0000;
         end
      end else if (st_q == S_EXEC) begin
         unique case (op)
            rlcex_pkg::OP_ADD, rlcex_pkg::OP_SUB, rlcex_pkg::OP_AND,
            rlcex_pkg::OP_OR: rf_q[f_rd] <= alu_res;
            rlcex_pkg::OP_LDI: rf_q[f_rd] <= {16'h0, instr[15:0]};
            rlcex_pkg::OP_MOVP: rf_q[f_rd] <= rd_reg(a_val[4:0]);
            rlcex_pkg::OP_LD, rlcex_pkg::OP_ST:
               if (f_mode[1]) begin
                  rf_q[f_cflag ? f_offr : f_rs1] <= upd;
               end
            default: ;
         endcase
      end else if (st_q == S_MEM && ld_q && (m0_ack || m1_ack)) begin
         rf_q[ldrd_q] <= m0_ack ? m0_rdata : m1_rdata;
      end else if (s_take && s_we && s_rg == rlcex_pkg::RG_DBG
                   && !s_addr[rlcex_pkg::DBG_CT_BIT] && st_q == S_HALT) begin
         rf_q[s_addr[6:2]] <= s_wdata;
      end
   end

   // run control: software write wins over the halt instruction
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_q <= rlcex_pkg::CTRL_RESET[rlcex_pkg::CTRL_RUN_BIT];
      end else if (s_take && s_we && s_rg == rlcex_pkg::RG_CTRL
                   && s_addr[7:0] == rlcex_pkg::CTRL_OFF) begin
         run_q <= s_wdata[rlcex_pkg::CTRL_RUN_BIT];
      end else if (st_q == S_EXEC && op == rlcex_pkg::OP_HALT) begin
         run_q <= 1'b0;
      end
   end

   // slave: take, then answer two edges later so ram data is ready
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_pend_q <= 1'b0;
         s_rg_q <= 2'h0;
         s_off_q <= 8'h00;
         s_ack <= 1'b0;
         s_rdata <= 32'h0000_0000;
         halted <= 1'b1;
      end else begin
         halted <= st_q == S_HALT;
         s_pend_q <= s_take;
         s_ack <= s_pend_q;
         if (s_take) begin
            s_rg_q <= s_rg;
            s_off_q <= s_addr[7:0];
         end
         if (s_pend_q) begin
            unique case (s_rg_q)
               rlcex_pkg::RG_INSTRUCTION_MEMORY: s_rdata <= halted ? ram_rdata
                                                     : 32'h0000_0000;
               rlcex_pkg::RG_CTRL: s_rdata <=
                  (s_off_q == rlcex_pkg::CTRL_OFF) ? {31'h0, run_q} :
                  (s_off_q == rlcex_pkg::STAT_OFF) ?
                     {20'h0, halted, pc_q} : 32'h0000_0000;
               rlcex_pkg::RG_DBG: s_rdata <= s_off_q[rlcex_pkg::DBG_CT_BIT]
                  ? ctab(s_off_q[6:2]) : rd_reg(s_off_q[6:2]);
               default: s_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: core/rlcex_pkg.sv */
// constants shared by the real-time core files
package rlcex_pkg;
   localparam int unsigned XLEN = 32;
   localparam int unsigned NREG = 32;
   localparam int unsigned INSTRUCTION_MEMORY_WORDS = 2048;
   localparam int unsigned INSTRUCTION_MEMORY_AW = 11;
   // instruction fields
   localparam int unsigned F_OP = 28;
   localparam int unsigned F_RD = 23;
   localparam int unsigned F_RS1 = 18;
   localparam int unsigned F_RS2 = 13;
   localparam int unsigned F_GRAN = 11;
   localparam int unsigned F_PART = 6;
   localparam int unsigned F_CFLAG = 17;
   localparam int unsigned F_MODE = 15;
   localparam int unsigned F_OFFR = 10;
   // opcodes
   localparam logic [3:0] OP_ADD = 4'h0;
   localparam logic [3:0] OP_SUB = 4'h1;
   localparam logic [3:0] OP_AND = 4'h2;
   localparam logic [3:0] OP_OR = 4'h3;
   localparam logic [3:0] OP_LDI = 4'h4;
   localparam logic [3:0] OP_MOVP = 4'h5;
   localparam logic [3:0] OP_LD = 4'h6;
   localparam logic [3:0] OP_ST = 4'h7;
   localparam logic [3:0] OP_JMP = 4'h8;
   localparam logic [3:0] OP_BNZ = 4'h9;
   localparam logic [3:0] OP_HALT = 4'hf;
   // operand granularity
   localparam logic [1:0] G_BIT = 2'h0;
   localparam logic [1:0] G_BYTE = 2'h1;
   localparam logic [1:0] G_HALF = 2'h2;
   localparam logic [1:0] G_WORD = 2'h3;
   // load/store address modes
   localparam logic [1:0] M_REGOFF = 2'h0;
   localparam logic [1:0] M_IMMOFF = 2'h1;
   localparam logic [1:0] M_POSTINC = 2'h2;
   localparam logic [1:0] M_PREDEC = 2'h3;
   // register indices
   localparam logic [4:0] IDX_REG = 5'h00;
   localparam logic [4:0] STAT_REG = 5'h1f;
   // data bus split: at or above this goes to memory interface 1
   localparam logic [31:0] SYS_BASE = 32'h0008_0000;
   // constants table entries
   localparam logic [31:0] CT_INTERRUPT_CONTROLLER_UNIT = 32'h0002_0000;
   localparam logic [31:0] CT_CAPT = 32'h0003_0000;
   localparam logic [31:0] CT_CFG = 32'h0002_6000;
   localparam logic [4:0] CT_IDX_INTERRUPT_CONTROLLER_UNIT = 5'h00;
   localparam logic [4:0] CT_IDX_CAPT = 5'h03;
   localparam logic [4:0] CT_IDX_CFG = 5'h04;
   // slave port map
   localparam int unsigned SAW = 16;
   localparam logic [1:0] RG_INSTRUCTION_MEMORY = 2'h0;
   localparam logic [1:0] RG_CTRL = 2'h1;
   localparam logic [1:0] RG_DBG = 2'h2;
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned DBG_CT_BIT = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

/* File: core/rlcex_ram.sv */
// single-port instruction memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rlcex_ram #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 2048,
   parameter int unsigned AW = 11
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

/* File: sim/rlcex_core_properties.sv */
// port assertions for the real-time core
`timescale 1ns/1ps
`default_nettype none
module rlcex_core_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_req,
   input wire logic s_ack,
   input wire logic m0_req,
   input wire logic m1_req,
   input wire logic m_we,
   input wire logic [31:0] m_addr,
   input wire logic [31:0] m_wdata,
   input wire logic m0_ack,
   input wire logic m1_ack,
   input wire logic halted
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_pulse: assert property (s_ack |=> !s_ack)
      else $error("slave ack longer than one cycle");
   a_ack_after_req: assert property ($rose(s_req) |-> ##2 s_ack)
      else $error("slave ack not two edges after request");
   a_ack_has_cause: assert property ($rose(s_ack) |-> $past(s_req, 2))
      else $error("slave ack without request");
   a_m0_held: assert property (m0_req && !m0_ack |=>
      m0_req && $stable(m_addr) && $stable(m_we) && $stable(m_wdata))
      else $error("local request dropped or changed before ack");
   a_m1_held: assert property (m1_req && !m1_ack |=>
      m1_req && $stable(m_addr) && $stable(m_we) && $stable(m_wdata))
      else $error("system request dropped or changed before ack");
   a_m0_local: assert property (m0_req |-> m_addr < rlcex_pkg::SYS_BASE)
      else $error("local interface used for system address");
   a_m1_system: assert property (m1_req |-> m_addr >= rlcex_pkg::SYS_BASE)
      else $error("system interface used for local address");
   a_one_access: assert property (!(m0_req && m1_req))
      else $error("two data accesses at once");
   a_halt_quiet: assert property (halted && $past(halted) |->
      !m0_req && !m1_req)
      else $error("data access while halted");
   a_req_ends: assert property ((m0_ack || m1_ack) && (m0_req || m1_req)
      |=> !m0_req && !m1_req)
      else $error("data request held after ack");
endmodule
bind rlcex_core rlcex_core_checker u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .s_req(s_req),
   .s_ack(s_ack),
   .m0_req(m0_req),
   .m1_req(m1_req),
   .m_we(m_we),
   .m_addr(m_addr),
   .m_wdata(m_wdata),
   .m0_ack(m0_ack),
   .m1_ack(m1_ack),
   .halted(halted)
);
`default_nettype wire

/* File: sim/rlcex_mem_model.sv */
// data memory behind one core data interface
`timescale 1ns/1ps
`default_nettype none
module rlcex_mem_model #(
   parameter logic [31:0] SEED = 32'h0000_0000,
   parameter int DLY = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic we,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic ack
);
   logic [31:0] mem [16];
   int cnt;
   always_ff @(posedge clk) begin
      ack <= 1'b0;
      // stale data toggles so a late sample never matches by luck
      rdata <= ~rdata;
      if (!rst_n) begin
         cnt <= 0;
         rdata <= 32'h0000_0000;
         // contents are set in reset so only this process writes them
         for (int i = 0; i < 16; i++) begin
            mem[i] <= SEED + 32'(i);
         end
      end else if (req && !ack) begin
         if (cnt == DLY) begin
            ack <= 1'b1;
            cnt <= 0;
            if (we) mem[addr[5:2]] <= wdata;
            else rdata <= mem[addr[5:2]];
         end else cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

/* File: sim/rlcex_core_tb_top.sv */
// self-checking bench for the real-time core
`timescale 1ns/1ps
`default_nettype none
module rlcex_core_tb_top;
   typedef struct {logic [31:0] a, b, ins, exp;} rlcex_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] ext_status = 32'h0000_0000;
   logic s_req = 1'b0;
   logic s_we = 1'b0;
   logic [15:0] s_addr = 16'h0000;
   logic [31:0] s_wdata = 32'h0000_0000;
   logic [31:0] s_rdata, m_addr, m_wdata, m0_rdata, m1_rdata, q;
   logic s_ack, m0_req, m1_req, m_we, m0_ack, m1_ack, halted;
   int bad_count = 0;
   int checks_done = 0;
   int lp = 0;
   rlcex_row_t rows [9];
   logic [31:0] ct [5];
   logic [31:0] ls [8];
   int lr [8];
   always #2.5 clk = ~clk;
   rlcex_core DUT (.clk(clk), .rst_n(rst_n), .ext_status(ext_status),
      .s_req(s_req), .s_we(s_we), .s_addr(s_addr), .s_wdata(s_wdata),
      .s_rdata(s_rdata), .s_ack(s_ack), .m0_req(m0_req), .m1_req(m1_req),
      .m_we(m_we), .m_addr(m_addr), .m_wdata(m_wdata), .m0_rdata(m0_rdata),
      .m0_ack(m0_ack), .m1_rdata(m1_rdata), .m1_ack(m1_ack),
      .halted(halted));
   rlcex_mem_model #(.SEED(32'hA000_0000), .DLY(0)) u_mem0 (.clk(clk),
      .rst_n(rst_n), .req(m0_req), .we(m_we), .addr(m_addr),
      .wdata(m_wdata), .rdata(m0_rdata), .ack(m0_ack));
   // the system side answers slowly
   rlcex_mem_model #(.SEED(32'hB000_0000), .DLY(4)) u_mem1 (.clk(clk),
      .rst_n(rst_n), .req(m1_req), .we(m_we), .addr(m_addr),
      .wdata(m_wdata), .rdata(m1_rdata), .ack(m1_ack));
   task automatic chk(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic sbus(input logic we, input logic [15:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      s_req <= 1'b1;
      s_we <= we;
      s_addr <= a;
      s_wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (s_ack !== 1'b1 && n < 20);
      q = s_rdata;
      s_req <= 1'b0;
      chk("ack delay", 32'(n), 32'h0000_0003);
      @(posedge clk);
   endtask
   task automatic wait_halt(input logic v);
      int n;
      n = 0;
      while (halted !== v && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("halted", 32'(halted), 32'(v));
   endtask
   task automatic put(input logic [31:0] w);
      sbus(1'b1, 16'(lp * 4), w);
      lp++;
   endtask
   task automatic go();
      sbus(1'b1, 16'h4000, 32'h0000_0001);
      wait_halt(1'b0);
      wait_halt(1'b1);
   endtask
   function automatic logic [15:0] dbg(input int n);
      return 16'h8000 + 16'(n * 4);
   endfunction
   function automatic logic [31:0] ldst(input logic [3:0] op,
         input logic [4:0] rd, rs, input logic c, input logic [1:0] md,
         input logic [4:0] ofr, input logic [7:0] im);
      return {op, rd, rs, c, md, ofr, 2'h0, im};
   endfunction
   localparam logic [31:0] HALT = {rlcex_pkg::OP_HALT, 28'h000_0000};
   localparam logic [17:0] R12 = {5'h01, 5'h02, 2'h3, 6'h00};
   initial begin
      rows = '{
         '{32'hFFFF_FFFF, 32'h0000_0002, {4'h0, 5'h03, R12, 5'h00},
            32'h0000_0001},
         '{32'h0000_0001, 32'h0000_0002, {4'h1, 5'h03, R12, 5'h00},
            32'hFFFF_FFFF},
         '{32'hF0F0_1234, 32'h0FF0_FFFF, {4'h2, 5'h03, R12, 5'h00},
            32'h00F0_1234},
         '{32'hF000_0000, 32'h0000_000F, {4'h3, 5'h03, R12, 5'h00},
            32'hF000_000F},
         '{32'h0000_0000, 32'h0000_0000, {4'h4, 5'h03, 7'h00, 16'hABCD},
            32'h0000_ABCD},
         '{32'h0000_0002, 32'h55AA_0000, {4'h5, 5'h03, 5'h01, 18'h0_0000},
            32'h55AA_0000},
         '{32'h0000_0010, 32'h0000_0020,
            {4'h0, 5'h03, 5'h01, 5'h02, 2'h0, 5'h05, 6'h00}, 32'h0000_0011},
         '{32'h0000_0100, 32'h00AB_0000,
            {4'h0, 5'h03, 5'h01, 5'h02, 2'h1, 5'h02, 6'h00}, 32'h0000_01AB},
         '{32'h0000_0001, 32'h1234_5678,
            {4'h0, 5'h03, 5'h01, 5'h02, 2'h2, 5'h01, 6'h00}, 32'h0000_1235}};
      ct = '{rlcex_pkg::CT_INTERRUPT_CONTROLLER_UNIT, 32'h0000_0000, 32'h0000_0000,
         rlcex_pkg::CT_CAPT, rlcex_pkg::CT_CFG};
      lr = '{4, 5, 6, 7, 1, 9, 10, 2};
      ls = '{32'hB000_0006, 32'hB000_0006, 32'hB000_0004, 32'hB000_0004,
         32'h0008_0010, 32'hB000_0006, 32'hB000_0006, 32'h0000_0004};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("halted", 32'(halted), 32'h0000_0001);
      chk("requests", 32'({m0_req, m1_req, s_ack}), 32'h0000_0000);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         sbus(1'b0, 16'h8080 + 16'(i * 4), 32'h0000_0000);
         chk("const", q, ct[i]);
      end
      ext_status <= 32'hC3A5_0F01;
      repeat (4) @(posedge clk);
      sbus(1'b1, dbg(31), 32'h0000_0000);
      sbus(1'b0, dbg(31), 32'h0000_0000);
      chk("status reg", q, 32'hC3A5_0F01);
      $display("table and status test done");
      foreach (rows[i]) begin
         sbus(1'b1, dbg(1), rows[i].a);
         sbus(1'b1, dbg(2), rows[i].b);
         put(rows[i].ins);
         put(HALT);
         go();
         sbus(1'b0, dbg(3), 32'h0000_0000);
         chk("row result", q, rows[i].exp);
         $display("row %0d done", i);
      end
      // both buses, both base kinds, and the auto modes in one program
      sbus(1'b1, dbg(1), 32'h0008_0010);
      sbus(1'b1, dbg(2), 32'h0000_0004);
      put(ldst(4'h6, 5'h04, 5'h01, 1'b0, 2'h1, 5'h00, 8'h08));
      put(ldst(4'h7, 5'h04, 5'h04, 1'b1, 2'h0, 5'h02, 8'h00));
      put(ldst(4'h6, 5'h05, 5'h04, 1'b1, 2'h1, 5'h00, 8'h04));
      put(ldst(4'h6, 5'h06, 5'h01, 1'b0, 2'h2, 5'h00, 8'h04));
      put(ldst(4'h6, 5'h07, 5'h01, 1'b0, 2'h3, 5'h00, 8'h04));
      put(ldst(4'h6, 5'h09, 5'h03, 1'b1, 2'h2, 5'h02, 8'h04));
      put(ldst(4'h6, 5'h0A, 5'h04, 1'b1, 2'h3, 5'h02, 8'h04));
      put(HALT);
      go();
      for (int i = 0; i < 8; i++) begin
         sbus(1'b0, dbg(lr[i]), 32'h0000_0000);
         chk("load store", q, ls[i]);
      end
      $display("load store test done");
      // a wrong branch or jump lands on a trap that overwrites register 8
      put({rlcex_pkg::OP_LDI, 5'h08, 7'h00, 16'h0001});
      put({rlcex_pkg::OP_BNZ, 10'h000, 7'h00, 11'(lp + 2)});
      put({rlcex_pkg::OP_BNZ, 5'h00, 5'h08, 7'h00, 11'(lp + 2)});
      put({rlcex_pkg::OP_LDI, 5'h08, 7'h00, 16'h0002});
      put({rlcex_pkg::OP_JMP, 17'h0_0000, 11'(lp + 2)});
      put({rlcex_pkg::OP_LDI, 5'h08, 7'h00, 16'h0003});
      put(HALT);
      go();
      sbus(1'b0, dbg(8), 32'h0000_0000);
      chk("branch reg", q, 32'h0000_0001);
      sbus(1'b0, 16'h4004, 32'h0000_0000);
      chk("status", q, 32'h0000_0800 + 32'(lp));
      sbus(1'b0, 16'h4000, 32'h0000_0000);
      chk("run bit", q, 32'h0000_0000);
      $display("branch test done");
      put({rlcex_pkg::OP_JMP, 17'h0_0000, 11'(lp)});
      put(32'h1234_5678);
      sbus(1'b1, 16'h4000, 32'h0000_0001);
      wait_halt(1'b0);
      sbus(1'b1, 16'((lp - 1) * 4), 32'hDEAD_0000);
      sbus(1'b0, 16'((lp - 1) * 4), 32'h0000_0000);
      chk("instruction_memory running", q, 32'h0000_0000);
      sbus(1'b1, 16'h4000, 32'h0000_0000);
      wait_halt(1'b1);
      sbus(1'b0, 16'((lp - 1) * 4), 32'h0000_0000);
      chk("instruction_memory halted", q, 32'h1234_5678);
      $display("instruction memory test done");
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
